// file: inc/wlsp_pkg.sv
// Shared constants and types for the write latch and sector protect block.
// Assumes a 24-bit flash address and SPI opcodes sent MSB first.
package wlsp_pkg;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06; // Set latch
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04; // Clear latch
   localparam logic [7:0] OP_PROTECT       = 8'h36; // Protect sector
   localparam logic [7:0] OP_UNPROTECT     = 8'h39; // Unprotect sector

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int         ADDR_W         = 24;      // Address width
   localparam logic [2:0] BYTES_OPCODE   = 3'h1;    // Bytes in opcode
   localparam logic [2:0] BYTES_ADDRESS  = 3'h4;    // Opcode plus address
   localparam logic [2:0] BIT_LAST       = 3'h7;    // Last bit of a byte

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       LATCH_RESET    = 1'b0;    // Latch after reset
   localparam logic       PROTECT_RESET  = 1'b1;    // Sector flag at reset

   // ----------------------------------------------------------------
   // Sector map defaults
   // ----------------------------------------------------------------
   localparam int         SECTOR_COUNT   = 4;       // Physical sectors
   localparam int         SECTOR_SHIFT   = 16;      // Low bits inside one

   // ----------------------------------------------------------------
   // Frame states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      WLSP_IDLE   = 4'b0001,
      WLSP_OPCODE = 4'b0010,
      WLSP_ADDR   = 4'b0100,
      WLSP_IGNORE = 4'b1000
   } wlsp_state_e;

   // Request from the program / erase engine to check permission
   typedef struct packed {
      logic              valid;       // One-cycle request pulse
      logic              needs_sector; // Program or erase of the array
      logic [ADDR_W-1:0] addr;        // Target address
   } wlsp_req_s;

endpackage

// file: hw/wlsp_core.sv
// Write enable latch and per-sector software protection for a serial
// flash. Assumes SPI pins arrive asynchronous to clock and are slow
// enough (several clock periods per serial clock phase) to oversample.
`timescale 1ns/1ps

module wlsp_core #(
   parameter int SECTORS = wlsp_pkg::SECTOR_COUNT, // Sector count
   parameter int SHIFT   = wlsp_pkg::SECTOR_SHIFT  // Sector size, log2
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                reset,
   // SPI pins from the host
   input  wire logic                spi_cs_n,
   input  wire logic                spi_sck,
   input  wire logic                spi_mosi,
   // Write protect pin
   input  wire logic                wp_n,
   // Lock bit from the status register
   input  wire logic                protection_lock_bit,
   // Permission check from the program / erase engine
   input  wire wlsp_pkg::wlsp_req_s op_req,
   output      logic                op_grant,
   output      logic                op_reject,
   // State seen by the rest of the device
   output      logic                write_enable_latch,
   output      logic [SECTORS-1:0]  sector_protect,
   output      logic                hard_locked
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int IDX_W = (SECTORS > 1) ? $clog2(SECTORS) : 1;

   logic                  cs_n_meta;    // First sync stage
   logic                  cs_n_sync;    // Second sync stage
   logic                  cs_n_prev;    // For deselect edge
   logic                  sck_meta;     // First sync stage
   logic                  sck_sync;     // Second sync stage
   logic                  sck_prev;     // For rising edge
   logic                  mosi_meta;    // First sync stage
   logic                  mosi_sync;    // Second sync stage
   logic                  wp_n_meta;    // First sync stage
   logic                  wp_n_sync;    // Second sync stage
   logic                  sck_rise;     // Serial clock rising edge
   logic                  cs_rise;      // End of frame
   logic                  cs_fall;      // Start of frame
   wlsp_pkg::wlsp_state_e state;        // Frame state
   logic [2:0]            bit_pos;      // Bit within current byte
   logic [2:0]            bytes_done;   // Whole bytes, saturating
   logic [7:0]            opcode;       // Captured opcode
   logic [wlsp_pkg::ADDR_W-1:0] addr_sh; // Address shifter
   logic                  aligned;      // Frame ends on byte boundary
   logic                  full_opcode;  // Opcode complete
   logic                  full_addr;    // Address complete
   logic                  is_sector_op; // Protect or unprotect
   logic                  frozen;       // Flags may not change
   logic [IDX_W-1:0]      frame_idx;    // Sector named by the frame
   logic [IDX_W-1:0]      req_idx;      // Sector named by the request

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two stages for every pin; edges come from the second stage only
   always_ff @(posedge clock) begin
      if (reset) begin
         cs_n_meta <= 1'b1;
         cs_n_sync <= 1'b1;
         sck_meta  <= 1'b0;
         sck_sync  <= 1'b0;
         mosi_meta <= 1'b0;
         mosi_sync <= 1'b0;
         wp_n_meta <= 1'b1;
         wp_n_sync <= 1'b1;
      end else begin
         cs_n_meta <= spi_cs_n;
         cs_n_sync <= cs_n_meta;
         sck_meta  <= spi_sck;
         sck_sync  <= sck_meta;
         mosi_meta <= spi_mosi;
         mosi_sync <= mosi_meta;
         wp_n_meta <= wp_n;
         wp_n_sync <= wp_n_meta;
      end
   end

   // Delayed copies for edge detection
   always_ff @(posedge clock) begin
      if (reset) begin
         cs_n_prev <= 1'b1;
         sck_prev  <= 1'b0;
      end else begin
         cs_n_prev <= cs_n_sync;
         sck_prev  <= sck_sync;
      end
   end

   // Mode 0 and 3 both sample on the rising edge
   assign sck_rise = sck_sync && !sck_prev && !cs_n_sync;
   assign cs_rise  = cs_n_sync && !cs_n_prev;
   assign cs_fall  = !cs_n_sync && cs_n_prev;

   // ----------------------------------------------------------------
   // Frame decode helpers
   // ----------------------------------------------------------------
   assign aligned      = (bit_pos == 3'h0);
   assign full_opcode  = (bytes_done >= wlsp_pkg::BYTES_OPCODE);
   assign full_addr    = (bytes_done >= wlsp_pkg::BYTES_ADDRESS);
   assign is_sector_op = (opcode == wlsp_pkg::OP_PROTECT) ||
                         (opcode == wlsp_pkg::OP_UNPROTECT);
   // Pin low with lock set is a hard lock; lock alone is soft
   assign frozen       = protection_lock_bit;
   // Bytes inside a sector do not matter
   assign frame_idx = IDX_W'(addr_sh >> SHIFT);
   assign req_idx   = IDX_W'(op_req.addr >> SHIFT);

   // ----------------------------------------------------------------
   // Frame state machine
   // ----------------------------------------------------------------
   // Tracks which part of the frame the next bit belongs to
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= wlsp_pkg::WLSP_IDLE;
      end else if (cs_rise) begin
         state <= wlsp_pkg::WLSP_IDLE;
      end else begin
         unique case (state)
            wlsp_pkg::WLSP_IDLE: begin
               if (cs_fall) begin
                  state <= wlsp_pkg::WLSP_OPCODE;
               end
            end
            wlsp_pkg::WLSP_OPCODE: begin
               if (sck_rise && bit_pos == wlsp_pkg::BIT_LAST) begin
                  // Latch commands carry nothing after the opcode
                  if (opcode[6:0] == wlsp_pkg::OP_PROTECT[7:1] ||
                      opcode[6:0] == wlsp_pkg::OP_UNPROTECT[7:1]) begin
                     state <= wlsp_pkg::WLSP_ADDR;
                  end else begin
                     state <= wlsp_pkg::WLSP_IGNORE;
                  end
               end
            end
            wlsp_pkg::WLSP_ADDR: begin
               // Bits after the third address byte are dropped
               if (sck_rise && bit_pos == wlsp_pkg::BIT_LAST &&
                   bytes_done == wlsp_pkg::BYTES_ADDRESS - 3'h1) begin
                  state <= wlsp_pkg::WLSP_IGNORE;
               end
            end
            wlsp_pkg::WLSP_IGNORE: begin
               state <= wlsp_pkg::WLSP_IGNORE;
            end
            default: begin
               state <= wlsp_pkg::WLSP_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bit and byte counters
   // ----------------------------------------------------------------
   // Bit position keeps running past the payload so that alignment
   // is still judged on trailing bits that are otherwise ignored
   always_ff @(posedge clock) begin
      if (reset || cs_fall) begin
         bit_pos    <= 3'h0;
         bytes_done <= 3'h0;
      end else if (sck_rise && state != wlsp_pkg::WLSP_IDLE) begin
         bit_pos <= bit_pos + 3'h1;
         if (bit_pos == wlsp_pkg::BIT_LAST &&
             bytes_done != wlsp_pkg::BYTES_ADDRESS) begin
            bytes_done <= bytes_done + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Shifters
   // ----------------------------------------------------------------
   // Opcode and address both arrive most significant bit first
   always_ff @(posedge clock) begin
      if (reset || cs_fall) begin
         opcode  <= 8'h00;
         addr_sh <= 24'h00_0000;
      end else if (sck_rise) begin
         if (state == wlsp_pkg::WLSP_OPCODE) begin
            opcode <= {opcode[6:0], mosi_sync};
         end
         if (state == wlsp_pkg::WLSP_ADDR) begin
            addr_sh <= {addr_sh[wlsp_pkg::ADDR_W-2:0], mosi_sync};
         end
      end
   end

   // ----------------------------------------------------------------
   // Write enable latch
   // ----------------------------------------------------------------
   // Acts only at deselect, after a frame that was really started
   always_ff @(posedge clock) begin
      if (reset) begin
         write_enable_latch <= wlsp_pkg::LATCH_RESET;
      end else if (cs_rise && state != wlsp_pkg::WLSP_IDLE) begin
         if (full_opcode && aligned &&
             opcode == wlsp_pkg::OP_WRITE_ENABLE) begin
            write_enable_latch <= 1'b1;
         end else if (full_opcode && aligned &&
                      opcode == wlsp_pkg::OP_WRITE_DISABLE) begin
            write_enable_latch <= 1'b0;
         end else if (full_opcode && is_sector_op) begin
            // Done, aborted or locked: the latch drops every time
            write_enable_latch <= 1'b0;
         end
         // A short or ragged latch frame leaves the latch alone
      end
   end

   // ----------------------------------------------------------------
   // Sector protection flags
   // ----------------------------------------------------------------
   // Without the latch set beforehand the host skipped a step, so the
   // command is dropped rather than trusted
   genvar s;
   generate
      for (s = 0; s < SECTORS; s++) begin : g_sector
         always_ff @(posedge clock) begin
            if (reset) begin
               sector_protect[s] <= wlsp_pkg::PROTECT_RESET;
            end else if (cs_rise && state != wlsp_pkg::WLSP_IDLE &&
                         full_addr && aligned && !frozen &&
                         write_enable_latch &&
                         frame_idx == IDX_W'(s)) begin
               if (opcode == wlsp_pkg::OP_PROTECT) begin
                  sector_protect[s] <= 1'b1;
               end else if (opcode == wlsp_pkg::OP_UNPROTECT) begin
                  sector_protect[s] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Lock indication
   // ----------------------------------------------------------------
   // Hard lock needs the pin high before the lock bit can be cleared
   always_ff @(posedge clock) begin
      if (reset) begin
         hard_locked <= 1'b0;
      end else begin
         hard_locked <= !wp_n_sync && protection_lock_bit;
      end
   end

   // ----------------------------------------------------------------
   // Permission check for writing commands
   // ----------------------------------------------------------------
   // Answered one cycle after the request, exactly one of the two
   always_ff @(posedge clock) begin
      if (reset) begin
         op_grant  <= 1'b0;
         op_reject <= 1'b0;
      end else if (op_req.valid) begin
         if (!write_enable_latch) begin
            op_grant  <= 1'b0;
            op_reject <= 1'b1;
         end else if (op_req.needs_sector &&
                      sector_protect[req_idx]) begin
            op_grant  <= 1'b0;
            op_reject <= 1'b1;
         end else begin
            op_grant  <= 1'b1;
            op_reject <= 1'b0;
         end
      end else begin
         op_grant  <= 1'b0;
         op_reject <= 1'b0;
      end
   end

endmodule

// file: tb/wlsp_core_checker.sv
// Concurrent checks on the ports of the write latch and sector protect core.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module wlsp_core_checker #(
   parameter int SECTORS = 4,  // Sector count
   parameter int SHIFT   = 16  // Sector size, log2
) (
   // Clock and reset
   input wire logic                clock,
   input wire logic                reset,
   // Pins
   input wire logic                spi_cs_n,
   input wire logic                spi_sck,
   input wire logic                spi_mosi,
   input wire logic                wp_n,
   input wire logic                protection_lock_bit,
   // Permission port
   input wire wlsp_pkg::wlsp_req_s op_req,
   input wire logic                op_grant,
   input wire logic                op_reject,
   // Device state
   input wire logic                write_enable_latch,
   input wire logic [SECTORS-1:0]  sector_protect,
   input wire logic                hard_locked
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic hit; // Flag of the sector a request targets
   assign hit = sector_protect[op_req.addr >> SHIFT];
   property p_grant;
      op_req.valid && write_enable_latch && !(op_req.needs_sector && hit)
      |=> op_grant && !op_reject;
   endproperty
   a_grant: assert property (p_grant) else $error("grant missing");
   property p_rej_latch;
      op_req.valid && !write_enable_latch |=> op_reject && !op_grant;
   endproperty
   a_rej_latch: assert property (p_rej_latch) else $error("latch");
   property p_rej_flag;
      op_req.valid && op_req.needs_sector && hit |=> op_reject && !op_grant;
   endproperty
   a_rej_flag: assert property (p_rej_flag) else $error("flag");
   property p_quiet;
      !op_req.valid |=> !op_grant && !op_reject;
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_latch_set;
      $rose(write_enable_latch) |-> spi_cs_n && $past(spi_cs_n, 3);
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("set");
   // Mid-frame nothing may move; effects wait for deselect
   property p_frame_hold;
      !spi_cs_n && !$past(spi_cs_n, 3) && !$past(spi_cs_n, 6)
      |-> $stable(write_enable_latch) && $stable(sector_protect);
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("hold");
   property p_flag_lock;
      $changed(sector_protect) |-> !$past(protection_lock_bit);
   endproperty
   a_flag_lock: assert property (p_flag_lock) else $error("lock");
   property p_flag_latch;
      $changed(sector_protect) |-> $past(write_enable_latch)
         && !write_enable_latch;
   endproperty
   a_flag_latch: assert property (p_flag_latch) else $error("no drop");
   property p_reset;
      disable iff (1'b0) reset |=> (&sector_protect) && !write_enable_latch;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values");
   property p_hard;
      (!wp_n && protection_lock_bit) [*4] |=> hard_locked;
   endproperty
   a_hard: assert property (p_hard) else $error("hard lock");
   c_grant: cover property (op_grant);
   c_flag: cover property ($changed(sector_protect));
   c_hard: cover property (hard_locked);
endmodule
bind wlsp_core wlsp_core_checker #(.SECTORS(SECTORS), .SHIFT(SHIFT)) u_chk (
   .clock(clock), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
   .spi_mosi(spi_mosi), .wp_n(wp_n),
   .protection_lock_bit(protection_lock_bit), .op_req(op_req),
   .op_grant(op_grant), .op_reject(op_reject),
   .write_enable_latch(write_enable_latch),
   .sector_protect(sector_protect), .hard_locked(hard_locked));

// file: tb/wlsp_spi_host.sv
// SPI host model: mode 0 or 3 frames, MSB first, slow against the clock.
// Assumes the bench clock; pins move just after its rising edge.
`timescale 1ns/1ps
module wlsp_spi_host (
   // Clock
   input wire logic clock,
   // SPI pins to the device
   output logic     spi_cs_n,
   output logic     spi_sck,
   output logic     spi_mosi
);
   localparam int PHASE = 5; // Clocks per phase, margin over the sync
   initial begin
      spi_cs_n = 1'b1;
      spi_sck  = 1'b0;
      spi_mosi = 1'b0;
   end
   // Sends nbits taken from bit 39 downward; mode3 idles sck high
   task automatic send(input logic [39:0] data, input int nbits,
                       input logic mode3);
      @(posedge clock);
      // Idle level settles while deselected, so no false edge
      spi_sck <= mode3;
      repeat (PHASE) @(posedge clock);
      spi_cs_n <= 1'b0;
      repeat (PHASE) @(posedge clock);
      for (int i = 0; i < nbits; i++) begin
         spi_mosi <= data[39-i];
         spi_sck  <= 1'b0;
         repeat (PHASE) @(posedge clock);
         spi_sck <= 1'b1;
         repeat (PHASE) @(posedge clock);
      end
      // Back to the idle level before deselect
      spi_sck <= mode3;
      repeat (PHASE) @(posedge clock);
      spi_cs_n <= 1'b1;
      // Released line shows no stale bit
      spi_mosi <= ~spi_mosi;
   endtask
endmodule

// file: tb/wlsp_core_tb.sv
// Self-checking bench for the write latch and sector protect core.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module wlsp_core_tb;
   logic                clock;       // 20 MHz clock
   logic                reset;       // Synchronous reset
   logic                spi_cs_n;    // Host pins
   logic                spi_sck;
   logic                spi_mosi;
   logic                wp_n;        // Write protect pin
   logic                lock;        // Lock bit level
   wlsp_pkg::wlsp_req_s op_req;      // Permission request
   logic                op_grant;
   logic                op_reject;
   logic                latch;       // Latch seen
   logic                mode3;       // Host frames in mode 3
   logic [3:0]          prot;        // Sector flags seen
   logic                hard;
   int                  miscompares;
   int                  check_count;
   localparam logic [7:0] WE = wlsp_pkg::OP_WRITE_ENABLE;
   localparam logic [7:0] WD = wlsp_pkg::OP_WRITE_DISABLE;
   localparam logic [7:0] PR = wlsp_pkg::OP_PROTECT;
   localparam logic [7:0] UP = wlsp_pkg::OP_UNPROTECT;
   wlsp_spi_host u_host (.clock(clock), .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi));
   wlsp_core u_dut (.clock(clock), .reset(reset), .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .wp_n(wp_n),
      .protection_lock_bit(lock), .op_req(op_req), .op_grant(op_grant),
      .op_reject(op_reject), .write_enable_latch(latch),
      .sector_protect(prot), .hard_locked(hard));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One frame to a sector address, then time for the effect to land
   task automatic frame(input logic [7:0] op, input logic [1:0] s, int n);
      u_host.send({op, 6'h00, s, 16'h5A3C, 8'hA5}, n, mode3);
      repeat (8) @(posedge clock);
   endtask
   // Permission request; the answer stands one cycle later
   task automatic ask(input logic [1:0] s, input logic nd, input logic g);
      @(posedge clock);
      op_req <= {1'b1, nd, 6'h00, s, 16'h0123};
      @(posedge clock);
      op_req.valid <= 1'b0;
      #1;
      check("grant", op_grant, g);
      check("reject", op_reject, !g);
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_latch;
      frame(WE, 2'd0, 8);
      check("latch set", latch, 1'b1);
      frame(WD, 2'd0, 16);
      check("latch clear", latch, 1'b0);
      frame(WE, 2'd0, 5);
      check("latch short", latch, 1'b0);
      frame(WE, 2'd0, 24);
      check("latch extra", latch, 1'b1);
      frame(WD, 2'd0, 12);
      check("latch odd", latch, 1'b1);
      // Shares seven bits with the protect opcode, yet does nothing
      frame(8'h37, 2'd1, 32);
      check("latch other op", latch, 1'b1);
      check("prot other op", prot, 4'b1111);
      ask(2'd1, 1'b0, 1'b1);
      ask(2'd1, 1'b1, 1'b0);
   endtask
   task automatic t_sector;
      frame(UP, 2'd2, 32);
      check("prot unp", prot, 4'b1011);
      check("latch unp", latch, 1'b0);
      ask(2'd2, 1'b1, 1'b0);
      frame(WE, 2'd0, 8);
      ask(2'd2, 1'b1, 1'b1);
      frame(UP, 2'd3, 40);
      check("prot tail", prot, 4'b0011);
      frame(WE, 2'd0, 8);
      frame(PR, 2'd2, 20);
      check("prot short", prot, 4'b0011);
      check("latch short", latch, 1'b0);
      frame(WE, 2'd0, 8);
      frame(PR, 2'd2, 40);
      check("prot set", prot, 4'b0111);
      check("latch prot", latch, 1'b0);
   endtask
   task automatic t_lock;
      @(posedge clock);
      lock <= 1'b1;
      frame(WE, 2'd0, 8);
      frame(PR, 2'd3, 32);
      check("prot lock", prot, 4'b0111);
      check("latch lock", latch, 1'b0);
      frame(WE, 2'd0, 8);
      frame(UP, 2'd0, 32);
      check("unp lock", prot, 4'b0111);
      check("latch unlk", latch, 1'b0);
      wp_n <= 1'b0;
      repeat (8) @(posedge clock);
      check("hard", hard, 1'b1);
      // Hard lock must freeze the flags as well
      frame(WE, 2'd0, 8);
      frame(UP, 2'd1, 32);
      check("unp hard", prot, 4'b0111);
      check("latch hard", latch, 1'b0);
      wp_n <= 1'b1;
      lock <= 1'b0;
      repeat (8) @(posedge clock);
      check("hard off", hard, 1'b0);
   endtask
   // Serial clock idling high must give the same bits
   task automatic t_mode3;
      mode3 = 1'b1;
      frame(WE, 2'd0, 8);
      check("latch mode3", latch, 1'b1);
      frame(UP, 2'd1, 32);
      check("prot mode3", prot, 4'b0101);
      mode3 = 1'b0;
   endtask
   task automatic t_reset;
      frame(WE, 2'd0, 8);
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      check("prot reset", prot, 4'b1111);
      check("latch reset", latch, 1'b0);
   endtask
   initial begin
      miscompares = 0;
      check_count = 0;
      reset = 1'b1;
      wp_n = 1'b1;
      lock = 1'b0;
      op_req = '0;
      mode3 = 1'b0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check("prot init", prot, 4'b1111);
      t_latch();
      t_sector();
      t_lock();
      t_mode3();
      t_reset();
      complete_run();
   end
   // Run needs under 10000 cycles; this cuts a hang short
   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      $display("watchdog expired");
      complete_run();
   end
endmodule
